// ===== rtl/adcsq_control.sv
// converter control, result registers and apb slave of the converter
`timescale 1ns/1ps
`default_nettype none
`include "adcsq_params.svh"

module adcsq_control (
  // clock, reset, enable
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // low power state from the cpu, same clock
  input wire logic halt_i,
  // analog front end
  input wire logic cmp_i,
  output logic [3:0] channel_o,
  output logic converter_on_o,
  output logic sample_o,
  output logic [9:0] dac_code_o,
  // interrupt
  output logic irq_o
);

  // reset images held as parameters, since a field cannot be selected from a bare literal
  localparam logic [7:0] CSR_RST = `ADCSQ_CSR_RST;
  localparam logic [9:0] RES_RST = `ADCSQ_RES_RST;

  // control/status fields
  logic eoc; // completion flag
  logic speed; // converter clock select
  logic converter_on; // software enable
  logic [3:0] input_selector; // channel field

  // result storage
  logic [7:0] result_high_byte; // result bits 9..2
  logic [1:0] result_low_bits; // result bits 1..0

  // interrupt registers
  logic irq_stat; // sticky completion event
  logic irq_mask; // enable for the event

  // comparator synchroniser
  logic cmp_meta; // first stage, read by second only
  logic cmp_sync; // safe to use

  // converter clock divider
  logic [1:0] div_cnt; // cpu clock cycle count
  logic conv_tick; // one cpu cycle per converter clock

  // engine handshakes
  logic run; // engine may run
  logic restart; // abort and restart on new input
  logic done; // conversion finished pulse
  logic done_q; // done seen one cycle ago
  logic [9:0] result; // latest engine result
  logic [9:0] trial; // engine trial code
  logic sample; // engine sampling

  // apb decode
  logic setup; // first cycle of a transfer
  logic access; // completing cycle of a transfer
  logic [9:0] word_idx; // register index of the address
  logic aligned; // low address bits zero
  logic hit_csr; // control/status selected
  logic hit_hi; // high result selected
  logic hit_lo; // low result selected
  logic hit_stat; // interrupt status selected
  logic hit_mask; // interrupt mask selected
  logic mapped; // any register selected
  logic [31:0] next_prdata; // read value for this address

  // control register write effects
  logic wr_csr; // control register written
  logic ch_changed; // new channel differs from old
  logic rd_hi_clr; // high result read may clear flag

  // bus phases and address decode
  always_comb begin
    setup = psel_i & ~penable_i;
    access = psel_i & penable_i & pready_o;
    word_idx = paddr_i[11:2];
    aligned = (paddr_i[1:0] == 2'b00);
    hit_csr = 1'b0;
    hit_hi = 1'b0;
    hit_lo = 1'b0;
    hit_stat = 1'b0;
    hit_mask = 1'b0;
    if (!aligned) begin
      hit_csr = 1'b0;
    end else if (word_idx == `ADCSQ_IDX_CSR) begin
      hit_csr = 1'b1;
    end else if (word_idx == `ADCSQ_IDX_RES_HI) begin
      hit_hi = 1'b1;
    end else if (word_idx == `ADCSQ_IDX_RES_LO) begin
      hit_lo = 1'b1;
    end else if (word_idx == `ADCSQ_IDX_IRQ_STAT) begin
      hit_stat = 1'b1;
    end else if (word_idx == `ADCSQ_IDX_IRQ_MASK) begin
      hit_mask = 1'b1;
    end
    mapped = hit_csr | hit_hi | hit_lo | hit_stat | hit_mask;
  end

  // read multiplexer; reserved bits read as zero
  always_comb begin
    next_prdata = `ADCSQ_RDATA_RST;
    if (hit_csr) begin
      next_prdata[`ADCSQ_EOC_BIT] = eoc;
      next_prdata[`ADCSQ_SPEED_BIT] = speed;
      next_prdata[`ADCSQ_ON_BIT] = converter_on;
      next_prdata[`ADCSQ_CH_MSB:`ADCSQ_CH_LSB] = input_selector;
    end else if (hit_hi) begin
      next_prdata[7:0] = result_high_byte;
    end else if (hit_lo) begin
      next_prdata[1:0] = result_low_bits;
    end else if (hit_stat) begin
      next_prdata[`ADCSQ_IRQ_DONE_BIT] = irq_stat;
    end else if (hit_mask) begin
      next_prdata[`ADCSQ_IRQ_DONE_BIT] = irq_mask;
    end
  end

  // side effects of the completing access
  always_comb begin
    wr_csr = access & pwrite_i & hit_csr;
    ch_changed = pwdata_i[`ADCSQ_CH_MSB:`ADCSQ_CH_LSB] != input_selector;
    // a completion landing after read data was captured keeps the flag
    rd_hi_clr = access & ~pwrite_i & hit_hi & ~done_q;
  end

  // ready one cycle after setup, data and error captured with it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= `ADCSQ_RDATA_RST;
    end else if (ce_i) begin
      pready_o <= setup;
      if (setup) begin
        pslverr_o <= ~mapped;
        prdata_o <= pwrite_i ? `ADCSQ_RDATA_RST : next_prdata;
      end
    end
  end

  // software fields of the control register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      speed <= CSR_RST[`ADCSQ_SPEED_BIT];
      converter_on <= CSR_RST[`ADCSQ_ON_BIT];
      input_selector <= `ADCSQ_CH_RST;
    end else if (ce_i && wr_csr) begin
      // reserved bit is dropped on write, reads back zero
      speed <= pwdata_i[`ADCSQ_SPEED_BIT];
      converter_on <= pwdata_i[`ADCSQ_ON_BIT];
      input_selector <= pwdata_i[`ADCSQ_CH_MSB:`ADCSQ_CH_LSB];
    end
  end

  // completion flag: set on done, cleared by high read or control write
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      eoc <= CSR_RST[`ADCSQ_EOC_BIT];
    end else if (ce_i) begin
      if (wr_csr && ch_changed) begin
        // a channel change clears even a completion of the old input
        eoc <= 1'b0;
      end else if (done) begin
        eoc <= 1'b1;
      end else if (wr_csr || rd_hi_clr) begin
        eoc <= 1'b0;
      end
    end
  end

  // results are not held back: every completion overwrites both
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      result_high_byte <= RES_RST[9:2];
      result_low_bits <= RES_RST[1:0];
    end else if (ce_i && done) begin
      result_high_byte <= result[9:2];
      result_low_bits <= result[1:0];
    end
  end

  // remember a completion for the read-clear guard
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      done_q <= 1'b0;
    end else if (ce_i) begin
      done_q <= done;
    end
  end

  // two-stage synchroniser for the analog comparator
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cmp_meta <= 1'b0;
      cmp_sync <= 1'b0;
    end else if (ce_i) begin
      cmp_meta <= cmp_i;
      cmp_sync <= cmp_meta;
    end
  end

  // run only while enabled and not halted; wait mode has no input here
  always_comb begin
    run = converter_on & ~halt_i;
    restart = wr_csr & ch_changed & pwdata_i[`ADCSQ_ON_BIT];
  end

  // converter clock as an enable pulse, no second clock domain
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_cnt <= 2'h0;
      conv_tick <= 1'b0;
    end else if (ce_i) begin
      if (!run) begin
        // held still while off, so the first tick after enable is full
        div_cnt <= 2'h0;
        conv_tick <= 1'b0;
      end else begin
        div_cnt <= div_cnt + 2'h1;
        conv_tick <= speed ? div_cnt[0] : (div_cnt == 2'h3);
      end
    end
  end

  // approximation engine; keeps going round while run is high
  adcsq_sar u_sar (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .run_i(run),
    .restart_i(restart),
    .tick_i(conv_tick),
    .cmp_i(cmp_sync),
    .trial_o(trial),
    .sample_o(sample),
    .result_o(result),
    .done_o(done)
  );

  // analog side outputs, registered
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      channel_o <= `ADCSQ_CH_RST;
      converter_on_o <= 1'b0;
      sample_o <= 1'b0;
      dac_code_o <= `ADCSQ_RES_RST;
    end else if (ce_i) begin
      channel_o <= input_selector;
      converter_on_o <= run;
      sample_o <= sample;
      dac_code_o <= trial;
    end
  end

  // sticky interrupt status, write one to clear, set wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat <= 1'b0;
    end else if (ce_i) begin
      if (done) begin
        irq_stat <= 1'b1;
      end else if (access && pwrite_i && hit_stat && pwdata_i[`ADCSQ_IRQ_DONE_BIT]) begin
        irq_stat <= 1'b0;
      end
    end
  end

  // interrupt mask register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_mask <= 1'b0;
    end else if (ce_i && access && pwrite_i && hit_mask) begin
      irq_mask <= pwdata_i[`ADCSQ_IRQ_DONE_BIT];
    end
  end

  // level interrupt, one cycle behind the status bit
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else if (ce_i) begin
      irq_o <= irq_stat & irq_mask;
    end
  end

endmodule // adcsq_control

`default_nettype wire

// ===== rtl/adcsq_params.svh
// constants for the converter sequencing control block
`ifndef ADCSQ_PARAMS_SVH
`define ADCSQ_PARAMS_SVH

// register indices; byte address is four times the index
`define ADCSQ_IDX_CSR 10'h070
`define ADCSQ_IDX_RES_HI 10'h071
`define ADCSQ_IDX_RES_LO 10'h072
`define ADCSQ_IDX_IRQ_STAT 10'h073
`define ADCSQ_IDX_IRQ_MASK 10'h074

// control/status field positions
`define ADCSQ_EOC_BIT 7
`define ADCSQ_SPEED_BIT 6
`define ADCSQ_ON_BIT 5
`define ADCSQ_RSVD_BIT 4
`define ADCSQ_CH_MSB 3
`define ADCSQ_CH_LSB 0

// interrupt status/mask field position
`define ADCSQ_IRQ_DONE_BIT 0

// reset values
`define ADCSQ_CSR_RST 8'h00
`define ADCSQ_RES_RST 10'h000
`define ADCSQ_CH_RST 4'h0
`define ADCSQ_RDATA_RST 32'h0000_0000

// converter timing in converter-clock ticks (count minus one)
`define ADCSQ_SAMPLE_LAST 3'h3
`define ADCSQ_BIT_LAST 3'h3
// first trial bit of the approximation
`define ADCSQ_MSB_IDX 4'h9
`define ADCSQ_MSB_TRIAL 10'h200

`endif

// ===== rtl/adcsq_pkg.sv
// types shared by the converter sequencing control block
package adcsq_pkg;

  // approximation engine states, gray coded along idle -> sample -> convert
  typedef enum logic [1:0] {
    ADCSQ_IDLE = 2'b00,
    ADCSQ_SAMPLE = 2'b01,
    ADCSQ_CONVERT = 2'b11
  } adcsq_sar_state_t;

endpackage

// ===== rtl/adcsq_sar.sv
// successive approximation engine stepping on the converter clock tick
`timescale 1ns/1ps
`default_nettype none
`include "adcsq_params.svh"

module adcsq_sar (
  // clock, reset, enable
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // control from the register side
  input wire logic run_i,
  input wire logic restart_i,
  input wire logic tick_i,
  // synchronised comparator: input at or above trial level
  input wire logic cmp_i,
  // results and analog side
  output logic [9:0] trial_o,
  output logic sample_o,
  output logic [9:0] result_o,
  output logic done_o
);

  adcsq_pkg::adcsq_sar_state_t state; // engine state
  logic [2:0] tcnt; // ticks spent in the current step
  logic [3:0] bidx; // bit under trial
  logic [9:0] bit_mask; // one-hot of the bit under trial
  logic [9:0] kept; // trial after the comparator decision
  logic [9:0] next_trial; // kept value plus the next trial bit

  // decide the current bit and prepare the next trial
  always_comb begin
    bit_mask = 10'h001 << bidx;
    kept = cmp_i ? trial_o : (trial_o & ~bit_mask);
    next_trial = kept | (bit_mask >> 1);
  end

  // sample, then ten decision steps, then sample again while running
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= adcsq_pkg::ADCSQ_IDLE;
      tcnt <= 3'h0;
      bidx <= 4'h0;
      trial_o <= `ADCSQ_RES_RST;
      sample_o <= 1'b0;
      result_o <= `ADCSQ_RES_RST;
      done_o <= 1'b0;
    end else if (ce_i) begin
      done_o <= 1'b0;
      if (!run_i) begin
        // off or halted: drop the conversion in progress
        state <= adcsq_pkg::ADCSQ_IDLE;
        tcnt <= 3'h0;
        trial_o <= `ADCSQ_RES_RST;
        sample_o <= 1'b0;
      end else if (restart_i) begin
        // new input chosen: abandon and sample afresh
        state <= adcsq_pkg::ADCSQ_SAMPLE;
        tcnt <= 3'h0;
        trial_o <= `ADCSQ_RES_RST;
        sample_o <= 1'b1;
      end else begin
        case (state)
          adcsq_pkg::ADCSQ_IDLE: begin
            state <= adcsq_pkg::ADCSQ_SAMPLE;
            tcnt <= 3'h0;
            sample_o <= 1'b1;
          end
          adcsq_pkg::ADCSQ_SAMPLE: begin
            if (tick_i) begin
              if (tcnt == `ADCSQ_SAMPLE_LAST) begin
                state <= adcsq_pkg::ADCSQ_CONVERT;
                tcnt <= 3'h0;
                bidx <= `ADCSQ_MSB_IDX;
                trial_o <= `ADCSQ_MSB_TRIAL;
                sample_o <= 1'b0;
              end else begin
                tcnt <= tcnt + 3'h1;
              end
            end
          end
          adcsq_pkg::ADCSQ_CONVERT: begin
            if (tick_i) begin
              if (tcnt == `ADCSQ_BIT_LAST) begin
                tcnt <= 3'h0;
                if (bidx == 4'h0) begin
                  // last bit decided: publish and go round again
                  result_o <= kept;
                  done_o <= 1'b1;
                  state <= adcsq_pkg::ADCSQ_SAMPLE;
                  trial_o <= `ADCSQ_RES_RST;
                  sample_o <= 1'b1;
                end else begin
                  bidx <= bidx - 4'h1;
                  trial_o <= next_trial;
                end
              end else begin
                tcnt <= tcnt + 3'h1;
              end
            end
          end
          default: begin
            state <= adcsq_pkg::ADCSQ_IDLE;
          end
        endcase
      end
    end
  end

endmodule // adcsq_sar

`default_nettype wire

// ===== tb/adcsq_control_properties.sv
// port assertions for the converter control block
`timescale 1ns/1ps
`default_nettype none
module adcsq_control_check (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // apb side
  input wire logic ce_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  // converter side
  input wire logic halt_i,
  input wire logic [3:0] channel_o,
  input wire logic converter_on_o,
  input wire logic sample_o,
  input wire logic irq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // setup, completing read or write, address decode
  wire logic su = ce_i && psel_i && !penable_i;
  wire logic rd = pready_o && psel_i && penable_i && !pwrite_i;
  wire logic wr = pready_o && psel_i && penable_i && pwrite_i;
  wire logic ok = paddr_i inside {12'h1C0, 12'h1C4, 12'h1C8, 12'h1CC, 12'h1D0};
  wire logic csr = paddr_i == 12'h1C0;
  // channel last written, compared once it reaches the pins
  logic [3:0] ch_w;
  always_ff @(posedge clk_i) begin
    if (wr && csr) ch_w <= pwdata_i[3:0];
  end
  answer_next_a: assert property (su |=> pready_o) else $error("no ready after setup");
  ready_once_a: assert property (pready_o |=> !pready_o) else $error("ready held");
  slverr_map_a: assert property (su |=> pslverr_o == !ok) else $error("slave error wrong");
  upper_zero_a: assert property (rd |-> prdata_o[31:8] == 24'h00_0000) else $error("upper bits set");
  low_pad_a: assert property (rd && paddr_i == 12'h1C8 |-> prdata_o[7:2] == 6'h00)
    else $error("low pad set");
  rsvd_zero_a: assert property (rd && csr |-> !prdata_o[4]) else $error("reserved bit set");
  chan_copy_a: assert property (wr && csr |-> ##2 channel_o == ch_w) else $error("channel pins");
  halt_off_a: assert property (halt_i |=> !converter_on_o) else $error("on in halt");
  halt_idle_a: assert property (halt_i [*3] |-> !sample_o) else $error("sampling in halt");
  off_idle_a: assert property (!converter_on_o [*4] |-> !$past(sample_o)) else $error("sampling off");
  reset_clear_a: assert property (disable iff (1'b0) rst_i |=> channel_o == 4'h0 && !converter_on_o && !irq_o)
    else $error("reset state");
endmodule // adcsq_control_check
`default_nettype wire

// ===== tb/test_adcsq_control.sv
// self-checking bench for the converter control block
`timescale 1ns/1ps
`default_nettype none
`include "adcsq_params.svh"
module test_adcsq_control;
  // register byte addresses
  localparam logic [11:0] CSR = {`ADCSQ_IDX_CSR, 2'b00};
  localparam logic [11:0] HI = {`ADCSQ_IDX_RES_HI, 2'b00};
  localparam logic [11:0] LO = {`ADCSQ_IDX_RES_LO, 2'b00};
  localparam logic [11:0] STA = {`ADCSQ_IDX_IRQ_STAT, 2'b00};
  localparam logic [11:0] MSK = {`ADCSQ_IDX_IRQ_MASK, 2'b00};
  // design ports; ce_i stays high except during the sample-phase hold test
  logic clk_i = 1'b0, rst_i = 1'b1, ce_i = 1'b1, psel_i = 1'b0, penable_i = 1'b0;
  logic pwrite_i = 1'b0, halt_i = 1'b0, cmp_i = 1'b0;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h0000_0000, prdata_o, rd;
  logic pready_o, pslverr_o, converter_on_o, sample_o, irq_o, er, s_q;
  logic [3:0] channel_o;
  logic [9:0] dac_code_o, lvl = 10'h2D7;
  logic [9:0] lv [3] = '{10'h3FF, 10'h000, 10'h155};
  int failures = 0, n_compared = 0;
  always #20 clk_i = ~clk_i;
  // analog input model: comparator high while level is at or above trial code
  always @(posedge clk_i) cmp_i <= lvl >= dac_code_o;
  always @(posedge clk_i) s_q <= sample_o;
  adcsq_control DUT (.clk_i, .rst_i, .ce_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
    .prdata_o, .pready_o, .pslverr_o, .halt_i, .cmp_i, .channel_o, .converter_on_o,
    .sample_o, .dac_code_o, .irq_o);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one apb transfer; an idle cycle always precedes the setup
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= {24'h00_0000, d};
    @(posedge clk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 20);
    if (n >= 20) failures++;
    rd = prdata_o;
    er = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  task automatic rdc(input logic [11:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h00);
    chk(rd, {24'h00_0000, e});
  endtask
  // wait for the interrupt line, bounded
  task automatic wirq();
    int n;
    n = 0;
    // a status clear only reaches the line two edges later
    repeat (2) @(posedge clk_i);
    while (irq_o !== 1'b1 && n < 400) begin
      @(posedge clk_i);
      n++;
    end
    chk(irq_o, 1'b1);
  endtask
  task automatic rise(output int n);
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (!(sample_o === 1'b1 && s_q === 1'b0) && n < 400);
  endtask
  // one full cycle is 44 converter ticks of d clocks each
  task automatic per(input int d);
    int n;
    rise(n);
    rise(n);
    chk(n >= 43 * d && n <= 45 * d, 1'b1);
  endtask
  task automatic test_done;
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial begin
    int i;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    rdc(CSR, 8'h00);
    rdc(HI, 8'h00);
    rdc(LO, 8'h00);
    // unmapped and misaligned places
    apb(1'b0, 12'h1D4, 8'h00);
    chk(er, 1'b1);
    apb(1'b1, 12'h1C1, 8'h20);
    chk(er, 1'b1);
    rdc(CSR, 8'h00);
    apb(1'b1, MSK, 8'h01);
    apb(1'b1, CSR, 8'h20);
    wirq();
    rdc(CSR, 8'hA0);
    rdc(LO, {6'h00, lvl[1:0]});
    rdc(CSR, 8'hA0);
    rdc(HI, lvl[9:2]);
    rdc(CSR, 8'h20);
    per(4);
    apb(1'b1, CSR, 8'h60);
    per(2);
    // clock enable low holds the engine early in its sample phase
    ce_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    rd = 32'({sample_o, dac_code_o});
    repeat (100) @(posedge clk_i);
    chk(32'({sample_o, dac_code_o}), rd);
    ce_i <= 1'b1;
    // each completion overwrites both results
    for (i = 0; i < 3; i++) begin
      lvl <= lv[i];
      apb(1'b1, STA, 8'h01);
      wirq();
      apb(1'b1, STA, 8'h01);
      wirq();
      rdc(CSR, 8'hE0);
      apb(1'b1, CSR, 8'h60);
      rdc(CSR, 8'h60);
      rdc(LO, {6'h00, lv[i][1:0]});
      rdc(HI, lv[i][9:2]);
    end
    apb(1'b1, STA, 8'h01);
    wirq();
    // every channel code, each change aborting and restarting
    for (i = 1; i <= 16; i++) begin
      apb(1'b1, CSR, {4'h6, i[3:0]});
      rdc(CSR, {4'h6, i[3:0]});
      chk(channel_o, i[3:0]);
      chk(sample_o, 1'b1);
    end
    // masked event still sets status
    apb(1'b1, MSK, 8'h00);
    apb(1'b1, STA, 8'h01);
    repeat (200) @(posedge clk_i);
    chk(irq_o, 1'b0);
    rdc(STA, 8'h01);
    apb(1'b1, MSK, 8'h01);
    repeat (2) @(posedge clk_i);
    chk(irq_o, 1'b1);
    // switched off: no completions, so the cleared line stays low
    apb(1'b1, CSR, 8'h40);
    apb(1'b1, STA, 8'h01);
    repeat (2) @(posedge clk_i);
    chk(irq_o, 1'b0);
    repeat (300) @(posedge clk_i);
    chk(converter_on_o, 1'b0);
    rdc(STA, 8'h00);
    // halt stops the converter, leaving it resumes
    apb(1'b1, CSR, 8'h60);
    halt_i <= 1'b1;
    apb(1'b1, STA, 8'h01);
    repeat (300) @(posedge clk_i);
    chk(converter_on_o, 1'b0);
    rdc(STA, 8'h00);
    halt_i <= 1'b0;
    wirq();
    test_done;
  end
  // hang guard, well beyond the few thousand cycles needed
  initial begin
    #800000;
    failures++;
    test_done;
  end
endmodule // test_adcsq_control
bind adcsq_control adcsq_control_check u_chk (.clk_i, .rst_i, .ce_i, .psel_i, .penable_i, .pwrite_i,
  .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .halt_i, .channel_o, .converter_on_o,
  .sample_o, .irq_o);
`default_nettype wire
